// ===== include/gca_pkg.sv
// Shared constants and types for the gated count acquisition sequencer.
package gca_pkg;
  localparam int NCH            = 8;
  localparam int CW             = 32;
  localparam int WORDS          = NCH + 1;
  localparam int AW             = 4;
  localparam int IDXW           = 27;
  localparam int CLK_NS         = 25;
  localparam int US_NS          = 1000;
  localparam int US_CYC         = US_NS / CLK_NS;
  localparam int OFF_ZERO_NS    = 200;
  localparam int OFF_ZERO_CYC   = (OFF_ZERO_NS / CLK_NS) < 1 ? 1 : (OFF_ZERO_NS / CLK_NS);
  localparam logic [16:0] FINAL_MAX   = 17'h1869f;
  localparam logic [16:0] FINAL_RESET = 17'h00000;
  localparam int FINAL_SCALE    = 1000;
  localparam logic [31:0] SNAP_BYTES  = 32'(WORDS * 4);
  localparam logic [31:0] RUN_RESET   = 32'h00004e20;
  localparam logic [31:0] OFF_RESET   = 32'h00004e20;
  localparam logic [39:0] DEFAULT_PREFIX = 40'h646174615f;
  localparam logic [7:0]  ASCII_ZERO  = 8'h30;
  localparam logic [11:0] SEQ_RESET   = 12'h001;

  typedef enum logic [5:0] {
    ST_IDLE     = 6'b000001,
    ST_LEVEL    = 6'b000010,
    ST_EDGE_ARM = 6'b000100,
    ST_EDGE_RUN = 6'b001000,
    ST_TMR_RUN  = 6'b010000,
    ST_TMR_OFF  = 6'b100000
  } acq_state_e;

  typedef enum logic [2:0] {
    CS_OFF   = 3'h0,
    CS_LEVEL = 3'h1,
    CS_TIMER = 3'h2,
    CS_EDGE  = 3'h3,
    CS_CONV  = 3'h4
  } capture_state_e;
endpackage : gca_pkg

// ===== verilog/microsecond_tick.sv
// Divider that gives a one-cycle enable pulse every microsecond.
`timescale 1ns/10ps
`default_nettype none
module microsecond_tick
  import gca_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic nrst,
  // Control
  input  wire logic restart,
  output logic      tick
);
  typedef struct packed {
    logic [5:0] cnt;
  } tick_s;

  tick_s s_r;
  tick_s s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    if (restart || s_r.cnt == 6'(US_CYC - 1))
      s_nxt.cnt = 6'h00;
    else
      s_nxt.cnt = s_r.cnt + 6'h01;
  end

  assign tick = !restart && (s_r.cnt == 6'(US_CYC - 1));

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
endmodule : microsecond_tick
`default_nettype wire

// ===== verilog/snapshot_store.sv
// Snapshot memory: all words written at once, read one word per cycle.
`timescale 1ns/10ps
`default_nettype none
module snapshot_store
  import gca_pkg::*;
(
  // Clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      nrst,
  // Parallel write
  input  wire logic                      capture,
  input  wire logic [WORDS-1:0][CW-1:0]  wr_words,
  // Registered read
  input  wire logic [AW-1:0]             rd_addr,
  output logic      [CW-1:0]             rd_data
);
  typedef struct packed {
    logic [WORDS-1:0][CW-1:0] mem;
    logic [CW-1:0]            rd;
  } store_s;

  store_s s_r;
  store_s s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    if (capture)
      s_nxt.mem = wr_words;
    // Reads see the contents from before this edge; the reader waits a cycle.
    s_nxt.rd = (rd_addr < AW'(WORDS)) ? s_r.mem[rd_addr] : '0;
  end

  assign rd_data = s_r.rd;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
endmodule : snapshot_store
`default_nettype wire

// ===== verilog/gated_count_acquisition.sv
// Acquisition sequencer: gated channel counters and snapshot output stream.
//
// Summary of operation
// - Level-gate mode counts while gate high, snapshots on every gate falling edge.
// - Edge-gate mode starts at first falling edge, then counts continuously.
// - Edge-gate mode takes each snapshot at the following rising gate edge.
// - File label is eight characters; longer names are cut to eight.
// - Without a given label a sequential default label is generated and reported.
// - Final sample number 0 to 99999 in thousands, readable back.
// - Acquisition stops itself when stored snapshots reach the final number.
// - Accumulated data size is tracked with the stored snapshots.
// - After reset every mode is stopped until its start command.
// - Start stores snapshots from current to end index, paced by the mode event.
// - Stop halts counting and acquisition at once in every mode.
// - Timer-gate mode paces snapshots from programmed run and off durations.
// - Run duration 1 to 4294967295 microseconds, readable back.
// - Off duration 0 to 4294967295 microseconds; zero gives an off interval of about 200ns.
// - In timer-gate mode the external gate still qualifies counting.
// - Gate polarity selectable positive or negative, positive after reset.
// - Capture state query reports level, timer, edge, conversion or off.
`timescale 1ns/10ps
`default_nettype none
module gated_count_acquisition
  import gca_pkg::*;
#(
  // Arbitrary value, not tied to any real hardware revision.
  parameter logic [7:0] HW_REVISION = 8'h01
)
(
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 nrst,
  // Count inputs and external gate
  input  wire logic [NCH-1:0]       count_pulse,
  input  wire logic                 gate_in,
  // Commands
  input  wire logic                 set_file_label,
  input  wire logic [63:0]          file_label_data,
  input  wire logic                 set_final_sample_number,
  input  wire logic [16:0]          final_sample_data,
  input  wire logic                 set_timer_run_duration,
  input  wire logic                 set_timer_off_duration,
  input  wire logic [31:0]          duration_data,
  input  wire logic                 set_gate_polarity,
  input  wire logic                 gate_polarity_neg,
  input  wire logic                 start_level_gate_capture,
  input  wire logic                 start_edge_gate_capture,
  input  wire logic                 start_timer_gate_capture,
  input  wire logic                 stop_capture,
  input  wire logic                 hex_conv_busy,
  // Query results
  output logic      [63:0]          query_file_label,
  output logic      [16:0]          query_final_sample_number,
  output logic      [31:0]          query_timer_run_duration,
  output logic      [31:0]          query_timer_off_duration,
  output logic      [2:0]           query_capture_state,
  output logic      [7:0]           query_hardware_revision,
  output logic                      gate_negative,
  output logic      [IDXW-1:0]      samples_stored,
  output logic      [31:0]          data_size_bytes,
  // Snapshot stream
  output logic                      snap_valid,
  input  wire logic                 snap_ready,
  output logic      [CW-1:0]        snap_word,
  output logic                      snap_last
);
  typedef struct packed {
    acq_state_e               st;
    logic                     gate_d;
    logic                     pol_neg;
    logic [63:0]              label;
    logic                     label_set;
    logic [11:0]              seq;
    logic [16:0]              final_n;
    logic [31:0]              run_dur;
    logic [31:0]              off_dur;
    logic [31:0]              phase;
    logic [3:0]               off_cyc;
    logic [NCH-1:0][CW-1:0]   cnt;
    logic [CW-1:0]            tmr;
    logic [IDXW-1:0]          sample_idx;
    logic [31:0]              bytes;
    logic                     out_prime;
    logic                     out_busy;
    logic [AW-1:0]            out_idx;
  } acq_s;

  acq_s                     s_r;
  acq_s                     s_nxt;
  logic                     gate_act;
  logic                     count_en;
  logic                     us_tick;
  logic                     tick_restart;
  logic                     capture;
  logic [IDXW-1:0]          end_idx;
  logic [NCH-1:0][CW-1:0]   cnt_step;
  logic [WORDS-1:0][CW-1:0] wr_words;
  logic                     any_start;
  logic                     capture_store;

  assign gate_act = gate_in ^ s_r.pol_neg;
  assign end_idx  = IDXW'(32'(s_r.final_n) * 32'(FINAL_SCALE));
  assign any_start = start_level_gate_capture || start_edge_gate_capture ||
                     start_timer_gate_capture;

  always_comb
  begin
    unique case (s_r.st)
      ST_LEVEL:    count_en = gate_act;
      ST_EDGE_RUN: count_en = 1'b1;
      ST_TMR_RUN:  count_en = gate_act;
      default:     count_en = 1'b0;
    endcase
  end

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++)
    begin : g_chan
      assign cnt_step[gi] = s_r.cnt[gi] + CW'(count_en && count_pulse[gi]);
      assign wr_words[gi] = s_r.cnt[gi];
    end
  endgenerate
  assign wr_words[NCH] = s_r.tmr;

  always_comb
  begin
    s_nxt        = s_r;
    capture      = 1'b0;
    tick_restart = 1'b0;
    s_nxt.gate_d = gate_act;
    s_nxt.cnt    = cnt_step;
    if (count_en && us_tick)
      s_nxt.tmr = s_r.tmr + 32'h1;

    // Settings are frozen while a run is in progress so a snapshot stays consistent.
    if (s_r.st == ST_IDLE)
    begin
      if (set_file_label)
      begin
        s_nxt.label      = file_label_data;
        s_nxt.label_set  = 1'b1;
        s_nxt.sample_idx = '0;
        s_nxt.bytes      = '0;
      end
      if (set_final_sample_number && final_sample_data <= FINAL_MAX)
        s_nxt.final_n = final_sample_data;
      if (set_timer_run_duration && duration_data != 32'h0)
        s_nxt.run_dur = duration_data;
      if (set_timer_off_duration)
        s_nxt.off_dur = duration_data;
      if (set_gate_polarity)
        s_nxt.pol_neg = gate_polarity_neg;
    end

    unique case (s_r.st)
      ST_IDLE:
      begin
        if (any_start && !stop_capture && s_r.sample_idx < end_idx)
        begin
          s_nxt.cnt     = '0;
          s_nxt.tmr     = '0;
          s_nxt.phase   = '0;
          s_nxt.off_cyc = '0;
          tick_restart  = 1'b1;
          // A fresh file starts its size from zero; a resumed one keeps adding.
          if (s_r.sample_idx == '0)
            s_nxt.bytes = '0;
          if (start_level_gate_capture)
            s_nxt.st = ST_LEVEL;
          else if (start_edge_gate_capture)
            s_nxt.st = ST_EDGE_ARM;
          else
            s_nxt.st = ST_TMR_RUN;
        end
      end
      ST_LEVEL:
        capture = s_r.gate_d && !gate_act;
      ST_EDGE_ARM:
        if (s_r.gate_d && !gate_act)
          s_nxt.st = ST_EDGE_RUN;
      ST_EDGE_RUN:
        capture = !s_r.gate_d && gate_act;
      ST_TMR_RUN:
      begin
        if (us_tick)
        begin
          if (s_r.phase + 32'h1 >= s_r.run_dur)
          begin
            capture     = 1'b1;
            s_nxt.phase = '0;
            s_nxt.st    = ST_TMR_OFF;
          end
          else
            s_nxt.phase = s_r.phase + 32'h1;
        end
      end
      ST_TMR_OFF:
      begin
        if (s_r.off_dur == 32'h0)
        begin
          // Zero off time is a short fixed gap in clock cycles.
          if (s_r.off_cyc == 4'(OFF_ZERO_CYC - 1))
          begin
            s_nxt.off_cyc = '0;
            s_nxt.st      = ST_TMR_RUN;
            tick_restart  = 1'b1;
          end
          else
            s_nxt.off_cyc = s_r.off_cyc + 4'h1;
        end
        else if (us_tick)
        begin
          if (s_r.phase + 32'h1 >= s_r.off_dur)
          begin
            s_nxt.phase = '0;
            s_nxt.st    = ST_TMR_RUN;
          end
          else
            s_nxt.phase = s_r.phase + 32'h1;
        end
      end
    endcase

    // A snapshot arriving while the last one still streams out is dropped;
    // the minimum period required of the gate source prevents this.
    if (capture && !s_r.out_busy && !s_r.out_prime && !stop_capture)
    begin
      s_nxt.out_prime  = 1'b1;
      s_nxt.sample_idx = s_r.sample_idx + IDXW'(1);
      s_nxt.bytes      = s_r.bytes + SNAP_BYTES;
      if (s_r.sample_idx + IDXW'(1) >= end_idx)
      begin
        s_nxt.st         = ST_IDLE;
        s_nxt.sample_idx = '0;
        s_nxt.label_set  = 1'b0;
        if (!s_r.label_set)
        begin
          s_nxt.seq[3:0] = s_r.seq[3:0] + 4'h1;
          if (s_r.seq[3:0] == 4'h9)
          begin
            s_nxt.seq[3:0] = 4'h0;
            s_nxt.seq[7:4] = s_r.seq[7:4] + 4'h1;
            if (s_r.seq[7:4] == 4'h9)
            begin
              s_nxt.seq[7:4]  = 4'h0;
              s_nxt.seq[11:8] = (s_r.seq[11:8] == 4'h9) ? 4'h0 : s_r.seq[11:8] + 4'h1;
            end
          end
        end
      end
    end

    if (stop_capture)
    begin
      s_nxt.st    = ST_IDLE;
      s_nxt.cnt   = s_r.cnt;
      s_nxt.tmr   = s_r.tmr;
      s_nxt.phase = '0;
    end

    if (s_r.out_prime)
    begin
      s_nxt.out_prime = 1'b0;
      s_nxt.out_busy  = 1'b1;
      s_nxt.out_idx   = '0;
    end
    else if (s_r.out_busy && snap_ready)
    begin
      if (s_r.out_idx == AW'(NCH))
        s_nxt.out_busy = 1'b0;
      else
        s_nxt.out_idx = s_r.out_idx + AW'(1);
    end
  end

  assign capture_store = capture && !s_r.out_busy && !s_r.out_prime && !stop_capture;

  microsecond_tick u_tick (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .restart (tick_restart),
    .tick    (us_tick)
  );

  // The store is loaded at the same edge as the capture decision, from the registered counts.
  snapshot_store u_store (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .capture  (capture_store),
    .wr_words (wr_words),
    .rd_addr  (s_nxt.out_idx),
    .rd_data  (snap_word)
  );

  always_comb
  begin
    if (s_r.label_set)
      query_file_label = s_r.label;
    else
      query_file_label = {DEFAULT_PREFIX,
                          ASCII_ZERO + {4'h0, s_r.seq[11:8]},
                          ASCII_ZERO + {4'h0, s_r.seq[7:4]},
                          ASCII_ZERO + {4'h0, s_r.seq[3:0]}};
  end

  always_comb
  begin
    unique case (s_r.st)
      ST_LEVEL:                query_capture_state = CS_LEVEL;
      ST_EDGE_ARM, ST_EDGE_RUN: query_capture_state = CS_EDGE;
      ST_TMR_RUN, ST_TMR_OFF:  query_capture_state = CS_TIMER;
      default:
        query_capture_state = (hex_conv_busy || s_r.out_busy || s_r.out_prime) ?
                              CS_CONV : CS_OFF;
    endcase
  end

  assign query_final_sample_number = s_r.final_n;
  assign query_timer_run_duration  = s_r.run_dur;
  assign query_timer_off_duration  = s_r.off_dur;
  assign query_hardware_revision   = HW_REVISION;
  assign gate_negative             = s_r.pol_neg;
  assign samples_stored            = s_r.sample_idx;
  assign data_size_bytes           = s_r.bytes;
  assign snap_valid                = s_r.out_busy;
  assign snap_last                 = s_r.out_busy && (s_r.out_idx == AW'(NCH));

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      s_r         <= '0;
      s_r.st      <= ST_IDLE;
      s_r.seq     <= SEQ_RESET;
      s_r.final_n <= FINAL_RESET;
      s_r.run_dur <= RUN_RESET;
      s_r.off_dur <= OFF_RESET;
    end
    else
      s_r <= s_nxt;
  end
endmodule : gated_count_acquisition
`default_nettype wire

// ===== tb/gate_source.sv
// External gate source model with a quiet flag around gate edges.
`timescale 1ns/10ps
`default_nettype none
module gate_source
#(
  parameter int HALF = 20
)
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic nrst,
  // Gate control and outputs
  input  wire logic run,
  output logic      gate_in,
  output logic      quiet
);
  int cnt;
  // The minimum gate period is scaled down to keep runs short; what it protects is
  // that each period outlasts the stream drain, so no capture is dropped.
  always @(posedge clk_sys or negedge nrst)
    if (!nrst || !run)
    begin
      cnt     <= 0;
      gate_in <= 1'b0;
    end
    else if (cnt == HALF - 1)
    begin
      cnt     <= 0;
      gate_in <= !gate_in;
    end
    else
      cnt <= cnt + 1;
  assign quiet = !run || cnt < 2 || cnt > HALF - 3;
endmodule : gate_source
`default_nettype wire

// ===== tb/gca_asserts.sv
// Port-level assertions for the acquisition sequencer.
`timescale 1ns/10ps
`default_nettype none
module gca_checker
  import gca_pkg::*;
(
  // Clock, reset and inputs
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        gate_in,
  input wire logic        set_final_sample_number,
  input wire logic [16:0] final_sample_data,
  input wire logic        set_timer_run_duration,
  input wire logic        set_timer_off_duration,
  input wire logic [31:0] duration_data,
  input wire logic        start_level_gate_capture,
  input wire logic        stop_capture,
  input wire logic        snap_ready,
  // Outputs
  input wire logic [16:0] query_final_sample_number,
  input wire logic [31:0] query_timer_run_duration,
  input wire logic [31:0] query_timer_off_duration,
  input wire logic [2:0]  query_capture_state,
  input wire logic        gate_negative,
  input wire logic [26:0] samples_stored,
  input wire logic [31:0] data_size_bytes,
  input wire logic        snap_valid,
  input wire logic [31:0] snap_word,
  input wire logic        snap_last
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  logic        idle;
  logic [31:0] limit;
  logic [31:0] stored;
  assign idle   = query_capture_state inside {CS_OFF, CS_CONV};
  assign limit  = {15'h0, query_final_sample_number} * 32'h3e8;
  assign stored = {5'h0, samples_stored};
  a_stop_halts: assert property (stop_capture |=> idle)
    else $error("run after stop");
  a_level_start: assert property (
    start_level_gate_capture && !stop_capture && idle && limit > stored
    |=> query_capture_state == CS_LEVEL) else $error("level start lost");
  a_final_range: assert property (
    set_final_sample_number && final_sample_data > FINAL_MAX
    |=> $stable(query_final_sample_number)) else $error("bad final taken");
  a_run_zero: assert property (
    set_timer_run_duration && duration_data == 32'h0
    |=> $stable(query_timer_run_duration)) else $error("zero run taken");
  a_off_load: assert property (
    set_timer_off_duration && idle
    |=> query_timer_off_duration == $past(duration_data)) else $error("off not loaded");
  a_stored_bound: assert property (!idle |-> stored < limit)
    else $error("count past final");
  a_size_tracks: assert property (!idle |-> data_size_bytes == stored * SNAP_BYTES)
    else $error("size wrong");
  a_level_capture: assert property (
    query_capture_state == CS_LEVEL && !gate_negative && $past(gate_in) && !gate_in
    && !snap_valid && !stop_capture |-> ##[1:3] snap_valid) else $error("no snapshot");
  a_word_hold: assert property (
    snap_valid && !snap_ready |=> snap_valid && $stable(snap_word) && $stable(snap_last))
    else $error("word moved in stall");
  a_last_ends: assert property (snap_valid && snap_ready && snap_last |=> !snap_valid)
    else $error("stream past last");
  c_level: cover property (query_capture_state == CS_LEVEL && snap_last);
  c_edge: cover property (query_capture_state == CS_EDGE && snap_last);
  c_timer: cover property (query_capture_state == CS_TIMER && snap_last);
  c_done: cover property ($rose(idle) && samples_stored == 27'h0);
endmodule : gca_checker
bind gated_count_acquisition gca_checker i_gca_checker (
  .clk_sys, .nrst, .gate_in, .set_final_sample_number, .final_sample_data,
  .set_timer_run_duration, .set_timer_off_duration, .duration_data,
  .start_level_gate_capture, .stop_capture, .snap_ready, .query_final_sample_number,
  .query_timer_run_duration, .query_timer_off_duration, .query_capture_state,
  .gate_negative, .samples_stored, .data_size_bytes, .snap_valid, .snap_word, .snap_last
);
`default_nettype wire

// ===== tb/gated_count_acquisition_bench.sv
// Self-checking bench for the gated count acquisition sequencer.
`timescale 1ns/10ps
`default_nettype none
module gated_count_acquisition_bench
  import gca_pkg::*;
();
  logic            clk_sys = 1'b0, nrst = 1'b0, snap_ready = 1'b0, hex_conv_busy = 1'b0;
  logic            gate_polarity_neg = 1'b0, gsrc_run = 1'b0, gate_in, quiet;
  logic            gate_negative, snap_valid, snap_last, gprev = 1'b0, armed = 1'b0;
  logic [8:0]      cmd = '0;
  logic [NCH-1:0]  count_pulse = '0;
  logic [63:0]     file_label_data = '0, query_file_label;
  logic [16:0]     final_sample_data = '0, query_final_sample_number, ef;
  logic [16:0]     fv[3] = '{17'h1869f, 17'h186a0, 17'h0};
  logic [31:0]     duration_data = '0, query_timer_run_duration, query_timer_off_duration;
  logic [31:0]     data_size_bytes, snap_word, er, eo, exp_q[$];
  logic [31:0]     dv[5] = '{32'h0, 32'hffffffff, 32'h1, 32'hffffffff, 32'h0};
  logic [2:0]      query_capture_state;
  logic [7:0]      hw_rev;
  // Arbitrary revision value, not tied to any real hardware.
  localparam logic [7:0] REV_ID = 8'h5a;
  logic [IDXW-1:0] samples_stored;
  int unsigned     cnt_m[NCH];
  int              fail_count = 0, check_count = 0, mode = 0, caps = 0, snaps = 0, w = 0;
  int              db[5] = '{2, 2, 2, 3, 3};

  gated_count_acquisition #(.HW_REVISION(REV_ID)) i_gated_count_acquisition (
    .clk_sys, .nrst, .count_pulse, .gate_in, .set_file_label(cmd[0]), .file_label_data,
    .set_final_sample_number(cmd[1]), .final_sample_data, .set_timer_run_duration(cmd[2]),
    .set_timer_off_duration(cmd[3]), .duration_data, .set_gate_polarity(cmd[4]),
    .gate_polarity_neg, .start_level_gate_capture(cmd[5]), .start_edge_gate_capture(cmd[6]),
    .start_timer_gate_capture(cmd[7]), .stop_capture(cmd[8]), .hex_conv_busy,
    .query_file_label, .query_final_sample_number, .query_timer_run_duration,
    .query_timer_off_duration, .query_capture_state, .query_hardware_revision(hw_rev),
    .gate_negative, .samples_stored, .data_size_bytes, .snap_valid, .snap_ready, .snap_word,
    .snap_last
  );
  gate_source i_gate_source (.clk_sys, .nrst, .run(gsrc_run), .gate_in, .quiet);

  always #12.5 clk_sys = ~clk_sys;

  // Reference model: counters, edge arming and expected snapshot words.
  always @(posedge clk_sys)
  begin
    if (mode == 2 && gprev && !gate_in)
      armed = 1'b1;
    if (mode == 1 && gate_in || armed)
      foreach (cnt_m[i]) cnt_m[i] += count_pulse[i];
    if (mode == 1 && gprev && !gate_in || armed && !gprev && gate_in)
    begin
      foreach (cnt_m[i]) exp_q.push_back(cnt_m[i]);
      caps++;
    end
    gprev = gate_in;
  end

  // Stream sink; in timer mode the gate stays inactive, so every word, timer too, is zero.
  always @(posedge clk_sys)
    if (snap_valid && snap_ready)
    begin
      if (w < 8 || mode == 3)
        check(snap_word, mode == 3 ? 32'h0 : exp_q.pop_front());
      check(snap_last, w == 8);
      w = (w == 8) ? 0 : w + 1;
      snaps += (w == 0);
    end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cmd_pulse(input int b);
    @(posedge clk_sys) cmd[b] <= 1'b1;
    @(posedge clk_sys) cmd[b] <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : cmd_pulse

  task automatic start(input int b, input int m, input logic [2:0] st);
    mode = m;
    armed = 1'b0;
    foreach (cnt_m[i]) cnt_m[i] = 0;
    cmd_pulse(b);
    check(query_capture_state, st);
  endtask : start

  task automatic stop_run();
    cmd_pulse(8);
    mode = 0;
    armed = 1'b0;
    gsrc_run <= 1'b0;
    check(query_capture_state, CS_OFF);
    check(samples_stored, caps);
    check(data_size_bytes, caps * SNAP_BYTES);
  endtask : stop_run

  task automatic wait_for(input int n);
    int t;
    for (t = 0; t < 90000 && (n > 0 ? snaps < n : query_capture_state !== CS_OFF); t++)
      @(posedge clk_sys);
    #1;
    if (t == 90000)
    begin
      fail_count++;
      $display("[ERR] %0t wait ran out, snaps %h", $time, snaps);
      results();
    end
  endtask : wait_for

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  initial
  begin
    void'($urandom(32'h3f5a7978));
    fork
      forever @(posedge clk_sys) count_pulse <= (quiet && mode != 3) ? '0 : NCH'($urandom);
      forever @(posedge clk_sys) snap_ready <= $urandom_range(3) != 0;
    join_none
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    #1;
    check(query_file_label, "data_001");
    check(query_timer_run_duration, 32'h4e20);
    check(query_timer_off_duration, 32'h4e20);
    check(gate_negative, 1'b0);
    check(hw_rev, REV_ID);
    check(query_capture_state, CS_OFF);
    hex_conv_busy <= 1'b1;
    #25;
    check(query_capture_state, CS_CONV);
    hex_conv_busy <= 1'b0;
    $display("test reset done");
    file_label_data <= "ABCDEFGH";
    cmd_pulse(0);
    check(query_file_label, "ABCDEFGH");
    ef = 17'h0;
    foreach (fv[k])
    begin
      final_sample_data <= fv[k];
      cmd_pulse(1);
      if (fv[k] <= FINAL_MAX)
        ef = fv[k];
      check(query_final_sample_number, ef);
    end
    start(5, 1, CS_OFF);
    final_sample_data <= 17'h1;
    cmd_pulse(1);
    er = 32'h4e20;
    eo = 32'h4e20;
    foreach (db[k])
    begin
      duration_data <= dv[k];
      cmd_pulse(db[k]);
      if (db[k] == 2 && dv[k] != 0)
        er = dv[k];
      if (db[k] == 3)
        eo = dv[k];
      check(query_timer_run_duration, er);
      check(query_timer_off_duration, eo);
    end
    for (int p = 1; p >= 0; p--)
    begin
      gate_polarity_neg <= p[0];
      cmd_pulse(4);
      check(gate_negative, p[0]);
    end
    $display("test settings done");
    start(5, 1, CS_LEVEL);
    gsrc_run <= 1'b1;
    wait_for(10);
    stop_run();
    $display("test level done");
    start(6, 2, CS_EDGE);
    gsrc_run <= 1'b1;
    wait_for(20);
    stop_run();
    $display("test edge done");
    // Run 1us and off zero: far below the advised period, yet longer than one drain.
    start(7, 3, CS_TIMER);
    wait_for(0);
    repeat (20) @(posedge clk_sys);
    check(samples_stored, 0);
    check(snaps, 1000);
    check(query_file_label, "data_001");
    $display("test timer done");
    results();
  end
endmodule : gated_count_acquisition_bench
`default_nettype wire
